// *** logic/ppfc_pkg.sv ***
`default_nettype none
package ppfc_pkg;

  // Register byte addresses on the control bus
  localparam logic [7:0] ADDR_P6_CFG    = 8'h00;
  localparam logic [7:0] ADDR_P7_CFG    = 8'h04;
  localparam logic [7:0] ADDR_P9_CFG    = 8'h08;
  localparam logic [7:0] ADDR_P11_CFG   = 8'h0C;
  localparam logic [7:0] ADDR_P12_CFG   = 8'h10;
  localparam logic [7:0] ADDR_P14_CFG   = 8'h14;
  localparam logic [7:0] ADDR_P13_LATCH = 8'h18;
  localparam logic [7:0] ADDR_P14_MODE  = 8'h1C;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h20;
  localparam logic [7:0] ADDR_EDGE_SEL  = 8'h24;
  localparam logic [7:0] ADDR_BG_EVENT  = 8'h28;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h30;

  // Port configuration word: direction, pull-up select, output latch, control mode
  localparam int CFG_DIR_LSB = 0;
  localparam int CFG_PU_LSB  = 8;
  localparam int CFG_LAT_LSB = 16;
  localparam int CFG_CTL_LSB = 24;

  // Index of each port inside the configuration array
  localparam int IDX_P6  = 0;
  localparam int IDX_P7  = 1;
  localparam int IDX_P9  = 2;
  localparam int IDX_P11 = 3;
  localparam int IDX_P12 = 4;
  localparam int IDX_P14 = 5;
  localparam int NUM_CFG = 6;

  // Implemented bits of each configuration word: {ctl, latch, pull-up, dir}
  localparam logic [NUM_CFG-1:0][31:0] CFG_MASK = {
    32'h3F3F_3F3F, 32'h0101_0101, 32'h0303_0003,
    32'h0001_0101, 32'hFFFF_FFFF, 32'hFFFF_F0FF};
  // After reset every pin is an input in port mode
  localparam logic [NUM_CFG-1:0][31:0] CFG_RST = CFG_MASK & {NUM_CFG{32'h0000_00FF}};

  localparam logic [7:0]  P6_OPEN_DRAIN  = 8'h0F;
  localparam logic [15:0] P14_MODE_MASK  = 16'h1C0C;
  localparam int          P14_OD_LSB     = 8;
  localparam logic [7:0]  BG_EVENT_MASK  = 8'h80;
  localparam int          FLASH_PU_BIT   = 7;
  localparam int          NUM_EXT        = 5;
  localparam int          NUM_IRQ        = 13;
  localparam int          EXT_IRQ_LSB    = 8;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic {WR_IDLE, WR_RESP} ppfc_wr_e;

  // Drive of one port towards its pad cells
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
  } ppfc_pad_s;

  typedef struct packed {
    logic [NUM_CFG-1:0][31:0] cfg;
    logic                     p13_latch;
    logic [15:0]              p14_mode;
    logic [2*NUM_EXT-1:0]     edge_sel;
    logic [7:0]               bg_event;
    logic [NUM_IRQ-1:0]       irq_status;
    logic [NUM_IRQ-1:0]       irq_mask;
    logic [7:0]               key_prev;
    logic [NUM_EXT-1:0]       ext_prev;
    logic [NUM_EXT-1:0]       ext_pulse;
    logic                     rst_done;
    ppfc_wr_e                 wr_state;
    logic                     aw_got;
    logic                     w_got;
    logic [7:0]               aw_addr;
    logic [31:0]              w_data;
    logic [3:0]               w_strb;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
  } ppfc_state_s;

endpackage : ppfc_pkg
`default_nettype wire

// *** logic/ppfc_top.sv ***
// Functional notes
// - Port 6 pins each set input or output
// - Port 6 pull-up only on bits four-seven
// - Port 6 bits zero-three are open-drain only
// - Port 7 direction, pull-up, key and interrupt inputs
// - External interrupts trigger rising, falling or both
// - Port 9 direction and pull-up select
// - Port 11 direction; control mode gives DAC outputs
// - Port 12 bit zero I/O, bits one-four input
// - Port 13 output-only, low during reset
// - Port 14 bits two-three select TTL input
// - Port 14 bits two-four push-pull or open-drain
// - Port 14 direction and pull-up per bit
// - Reset input active low holds device reset
// - Flash mode pin pulled down during reset
// - Self-programming switches flash pin to pull-up
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`default_nettype none
module ppfc_top (
  input  wire logic                core_clk,                  // 125 MHz clock
  input  wire logic                rst_n,                     // Async reset, low active
  input  wire logic [7:0]          s_axi_awaddr,              // Write address
  input  wire logic                s_axi_awvalid,             // Write address valid
  output logic                     s_axi_awready,             // Write address ready
  input  wire logic [31:0]         s_axi_wdata,               // Write data
  input  wire logic [3:0]          s_axi_wstrb,               // Byte strobes
  input  wire logic                s_axi_wvalid,              // Write data valid
  output logic                     s_axi_wready,              // Write data ready
  output logic [1:0]               s_axi_bresp,               // Write response
  output logic                     s_axi_bvalid,              // Write response valid
  input  wire logic                s_axi_bready,              // Write response ready
  input  wire logic [7:0]          s_axi_araddr,              // Read address
  input  wire logic                s_axi_arvalid,             // Read address valid
  output logic                     s_axi_arready,             // Read address ready
  output logic [31:0]              s_axi_rdata,               // Read data
  output logic [1:0]               s_axi_rresp,               // Read response
  output logic                     s_axi_rvalid,              // Read data valid
  input  wire logic                s_axi_rready,              // Read data ready
  input  wire logic [7:0]          p6_in,                     // Port 6 pad levels
  input  wire logic [7:0]          p7_in,                     // Port 7 pad levels
  input  wire logic                p9_in,                     // Port 9 pad level
  input  wire logic [1:0]          p11_in,                    // Port 11 pad levels
  input  wire logic [4:0]          p12_in,                    // Port 12 pad levels
  input  wire logic [5:0]          p14_in,                    // Port 14 pad levels
  input  wire logic [7:0]          p6_alt_out,                // Serial function data
  input  wire logic [7:0]          p6_alt_oe,                 // Serial function enable
  input  wire logic [5:0]          p14_alt_out,               // Timer/serial/buzzer data
  input  wire logic [5:0]          p14_alt_oe,                // Timer/serial/buzzer enable
  input  wire logic                self_prog_active,          // Self-programming entered
  output ppfc_pkg::ppfc_pad_s      p6_pad,                    // Port 6 pad drive
  output ppfc_pkg::ppfc_pad_s      p7_pad,                    // Port 7 pad drive
  output ppfc_pkg::ppfc_pad_s      p9_pad,                    // Port 9 pad drive
  output ppfc_pkg::ppfc_pad_s      p11_pad,                   // Port 11 pad drive
  output ppfc_pkg::ppfc_pad_s      p12_pad,                   // Port 12 pad drive
  output ppfc_pkg::ppfc_pad_s      p14_pad,                   // Port 14 pad drive
  output logic                     port13_output_pin,         // Output-only pin
  output logic [7:0]               key_interrupt_inputs,      // Key levels to key block
  output logic [3:0]               port7_external_irq_inputs, // Edge events, one cycle
  output logic                     port12_external_irq_input, // Edge event, one cycle
  output logic                     dac_output_0,              // Analog switch enable 0
  output logic                     dac_output_1,              // Analog switch enable 1
  output logic [1:0]               port14_ttl_select,         // TTL buffer on bits 3:2
  output logic                     flash_mode_pin_pull_up,    // Flash pin pull-up on
  output logic                     flash_mode_pin_pull_down,  // Flash pin pull-down on
  output logic                     irq                        // Level interrupt
);
  import ppfc_pkg::*;

  ppfc_state_s st_reg;
  ppfc_state_s st_next;
  logic [NUM_EXT-1:0] ext_cur;
  logic [NUM_EXT-1:0] ext_en;
  logic [7:0]         key_evt;
  logic [NUM_EXT-1:0] ext_evt;
  logic [31:0]        pin_level;
  logic               wr_fire;
  logic [31:0]        wr_word;
  logic [NUM_IRQ-1:0] irq_clear;

  // Merge the strobed bytes of a write into the old value
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // Pad drive of a port from its word, alternate function and open-drain set
  function automatic ppfc_pad_s pad_drive(input logic [31:0] cfg,
                                          input logic [7:0]  io_mask,
                                          input logic [7:0]  alt_o,
                                          input logic [7:0]  alt_oe,
                                          input logic [7:0]  od);
    ppfc_pad_s p;
    logic      ctl;
    logic      val;
    logic      en;
    p   = '0;
    ctl = 1'b0;
    val = 1'b0;
    en  = 1'b0;
    for (int i = 0; i < 8; i++) begin
      ctl = cfg[CFG_CTL_LSB+i];
      val = ctl ? alt_o[i] : cfg[CFG_LAT_LSB+i];
      en  = io_mask[i] & (ctl ? alt_oe[i] : ~cfg[CFG_DIR_LSB+i]);
      if (od[i]) begin
        p.out[i] = 1'b0;
        p.oe[i]  = en & ~val;
      end else begin
        p.out[i] = val;
        p.oe[i]  = en;
      end
      // Pull-up only acts on a pin that is an input in port mode
      p.pull_up[i] = cfg[CFG_PU_LSB+i] & cfg[CFG_DIR_LSB+i] & ~ctl;
    end
    return p;
  endfunction : pad_drive

  // External interrupt inputs: index 0 is the port 12 pin, 1-4 port 7 bits 4-7
  assign ext_cur = {p7_in[7:4], p12_in[0]};
  assign ext_en  = {st_reg.cfg[IDX_P7][CFG_CTL_LSB+4 +: 4],
                    st_reg.cfg[IDX_P12][CFG_CTL_LSB]};
  // Key events on a falling edge; keys are wired to ground in usual use
  assign key_evt = st_reg.cfg[IDX_P7][CFG_CTL_LSB +: 8] & st_reg.key_prev & ~p7_in;

  // Edge select: even bit enables rising, odd bit enables falling
  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      ext_evt[i] = ext_en[i] &
                   ((st_reg.edge_sel[2*i]   & ~st_reg.ext_prev[i] &  ext_cur[i]) |
                    (st_reg.edge_sel[2*i+1] &  st_reg.ext_prev[i] & ~ext_cur[i]));
    end
  end

  assign pin_level = {2'h0, p14_in, p12_in, p11_in, p9_in, p7_in, p6_in};
  assign wr_fire   = (st_reg.wr_state == WR_IDLE) &&
                     (st_reg.aw_got || s_axi_awvalid) && (st_reg.w_got || s_axi_wvalid);
  assign wr_word   = st_reg.w_got ? st_reg.w_data : s_axi_wdata;

  // Write-one-to-clear of interrupt status
  always_comb begin
    irq_clear = '0;
    if (wr_fire && ((st_reg.aw_got ? st_reg.aw_addr : s_axi_awaddr) == ADDR_IRQ_STAT)) begin
      irq_clear = NUM_IRQ'(merge_strb(32'h0, wr_word,
                                      st_reg.w_got ? st_reg.w_strb : s_axi_wstrb));
    end
  end

  // Whole next-state: bus slave, registers, edge history, interrupts
  always_comb begin
    logic [7:0]  a;
    logic [3:0]  s;
    logic [31:0] rd;
    logic        hit;
    st_next = st_reg;
    a       = st_reg.aw_got ? st_reg.aw_addr : s_axi_awaddr;
    s       = st_reg.w_got ? st_reg.w_strb : s_axi_wstrb;
    rd      = '0;
    hit     = 1'b1;
    st_next.rst_done  = 1'b1;
    st_next.key_prev  = p7_in;
    st_next.ext_prev  = ext_cur;
    st_next.ext_pulse = ext_evt;
    // A new event wins over a clear in the same cycle
    st_next.irq_status = (st_reg.irq_status & ~irq_clear) | {ext_evt, key_evt};
    // Address and data are taken in either order and held until both are here
    if (st_reg.wr_state == WR_IDLE) begin
      if (!st_reg.aw_got && s_axi_awvalid) begin
        st_next.aw_got  = 1'b1;
        st_next.aw_addr = s_axi_awaddr;
      end
      if (!st_reg.w_got && s_axi_wvalid) begin
        st_next.w_got  = 1'b1;
        st_next.w_data = s_axi_wdata;
        st_next.w_strb = s_axi_wstrb;
      end
      if (wr_fire) begin
        if (a == ADDR_P6_CFG) begin
          st_next.cfg[IDX_P6] = merge_strb(st_reg.cfg[IDX_P6], wr_word, s)
                                & CFG_MASK[IDX_P6];
        end else if (a == ADDR_P7_CFG) begin
          st_next.cfg[IDX_P7] = merge_strb(st_reg.cfg[IDX_P7], wr_word, s)
                                & CFG_MASK[IDX_P7];
        end else if (a == ADDR_P9_CFG) begin
          st_next.cfg[IDX_P9] = merge_strb(st_reg.cfg[IDX_P9], wr_word, s)
                                & CFG_MASK[IDX_P9];
        end else if (a == ADDR_P11_CFG) begin
          st_next.cfg[IDX_P11] = merge_strb(st_reg.cfg[IDX_P11], wr_word, s)
                                 & CFG_MASK[IDX_P11];
        end else if (a == ADDR_P12_CFG) begin
          st_next.cfg[IDX_P12] = merge_strb(st_reg.cfg[IDX_P12], wr_word, s)
                                 & CFG_MASK[IDX_P12];
        end else if (a == ADDR_P14_CFG) begin
          st_next.cfg[IDX_P14] = merge_strb(st_reg.cfg[IDX_P14], wr_word, s)
                                 & CFG_MASK[IDX_P14];
        end else if (a == ADDR_P13_LATCH) begin
          st_next.p13_latch = s[0] ? wr_word[0] : st_reg.p13_latch;
        end else if (a == ADDR_P14_MODE) begin
          st_next.p14_mode = 16'(merge_strb({16'h0, st_reg.p14_mode}, wr_word, s))
                             & P14_MODE_MASK;
        end else if (a == ADDR_EDGE_SEL) begin
          st_next.edge_sel = 10'(merge_strb({22'h0, st_reg.edge_sel}, wr_word, s));
        end else if (a == ADDR_BG_EVENT) begin
          st_next.bg_event = 8'(merge_strb({24'h0, st_reg.bg_event}, wr_word, s))
                             & BG_EVENT_MASK;
        end else if (a == ADDR_IRQ_MASK) begin
          st_next.irq_mask = NUM_IRQ'(merge_strb({19'h0, st_reg.irq_mask}, wr_word, s));
        end else if (a == ADDR_IRQ_STAT || a == ADDR_PIN_LEVEL) begin
          hit = 1'b1;
        end else begin
          hit = 1'b0;
        end
        st_next.bresp    = hit ? RESP_OKAY : RESP_SLVERR;
        st_next.wr_state = WR_RESP;
        st_next.aw_got   = 1'b0;
        st_next.w_got    = 1'b0;
      end
    end else if (s_axi_bready) begin
      st_next.wr_state = WR_IDLE;
    end
    // Reads answer one cycle after the address is taken
    if (!st_reg.rvalid) begin
      if (s_axi_arvalid) begin
        hit = 1'b1;
        if (s_axi_araddr == ADDR_P6_CFG) begin
          rd = st_reg.cfg[IDX_P6];
        end else if (s_axi_araddr == ADDR_P7_CFG) begin
          rd = st_reg.cfg[IDX_P7];
        end else if (s_axi_araddr == ADDR_P9_CFG) begin
          rd = st_reg.cfg[IDX_P9];
        end else if (s_axi_araddr == ADDR_P11_CFG) begin
          rd = st_reg.cfg[IDX_P11];
        end else if (s_axi_araddr == ADDR_P12_CFG) begin
          rd = st_reg.cfg[IDX_P12];
        end else if (s_axi_araddr == ADDR_P14_CFG) begin
          rd = st_reg.cfg[IDX_P14];
        end else if (s_axi_araddr == ADDR_P13_LATCH) begin
          rd = {31'h0, st_reg.p13_latch};
        end else if (s_axi_araddr == ADDR_P14_MODE) begin
          rd = {16'h0, st_reg.p14_mode};
        end else if (s_axi_araddr == ADDR_PIN_LEVEL) begin
          rd = pin_level;
        end else if (s_axi_araddr == ADDR_EDGE_SEL) begin
          rd = {22'h0, st_reg.edge_sel};
        end else if (s_axi_araddr == ADDR_BG_EVENT) begin
          rd = {24'h0, st_reg.bg_event};
        end else if (s_axi_araddr == ADDR_IRQ_STAT) begin
          rd = {19'h0, st_reg.irq_status};
        end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
          rd = {19'h0, st_reg.irq_mask};
        end else begin
          hit = 1'b0;
        end
        st_next.rvalid = 1'b1;
        st_next.rdata  = rd;
        st_next.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // State register; the reset pin holds everything at its reset value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg            <= '0;
      st_reg.cfg        <= CFG_RST;
      st_reg.key_prev   <= 8'hFF;
      st_reg.wr_state   <= WR_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Bus handshakes
  assign s_axi_awready = (st_reg.wr_state == WR_IDLE) && !st_reg.aw_got;
  assign s_axi_wready  = (st_reg.wr_state == WR_IDLE) && !st_reg.w_got;
  assign s_axi_bvalid  = (st_reg.wr_state == WR_RESP);
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  // Pads; port 7, 11 and 12 functions are inputs or analog, so they never drive
  assign p6_pad  = pad_drive(st_reg.cfg[IDX_P6], CFG_MASK[IDX_P6][7:0],
                             p6_alt_out, p6_alt_oe, P6_OPEN_DRAIN);
  assign p7_pad  = pad_drive(st_reg.cfg[IDX_P7], CFG_MASK[IDX_P7][7:0],
                             8'h00, 8'h00, 8'h00);
  assign p9_pad  = pad_drive(st_reg.cfg[IDX_P9], CFG_MASK[IDX_P9][7:0],
                             8'h00, 8'h00, 8'h00);
  assign p11_pad = pad_drive(st_reg.cfg[IDX_P11], CFG_MASK[IDX_P11][7:0],
                             8'h00, 8'h00, 8'h00);
  assign p12_pad = pad_drive(st_reg.cfg[IDX_P12], CFG_MASK[IDX_P12][7:0],
                             8'h00, 8'h00, 8'h00);
  assign p14_pad = pad_drive(st_reg.cfg[IDX_P14], CFG_MASK[IDX_P14][7:0],
                             {2'h0, p14_alt_out}, {2'h0, p14_alt_oe},
                             st_reg.p14_mode[P14_OD_LSB +: 8]);

  assign port13_output_pin         = st_reg.p13_latch;
  assign key_interrupt_inputs      = p7_in & st_reg.cfg[IDX_P7][CFG_CTL_LSB +: 8];
  assign port7_external_irq_inputs = st_reg.ext_pulse[4:1];
  assign port12_external_irq_input = st_reg.ext_pulse[0];
  assign dac_output_0              = st_reg.cfg[IDX_P11][CFG_CTL_LSB];
  assign dac_output_1              = st_reg.cfg[IDX_P11][CFG_CTL_LSB+1];
  assign port14_ttl_select         = st_reg.p14_mode[3:2];
  // Pull-down until reset is over; pull-up by software or self-programming
  assign flash_mode_pin_pull_up    = st_reg.rst_done &
                                     (st_reg.bg_event[FLASH_PU_BIT] | self_prog_active);
  assign flash_mode_pin_pull_down  = ~flash_mode_pin_pull_up;
  assign irq                       = |(st_reg.irq_status & st_reg.irq_mask);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_p6_no_high: assert property ((p6_pad.oe[3:0] & p6_pad.out[3:0]) == 4'h0)
    else $error("port 6 low pin drove high");
  a_p6_pull_low: assert property (p6_pad.pull_up[3:0] == 4'h0)
    else $error("port 6 low pin got pull-up");
  a_p6_dir_in: assert property (st_reg.cfg[IDX_P6][0] && !st_reg.cfg[IDX_P6][24]
                                |-> !p6_pad.oe[0])
    else $error("port 6 input pin driven");
  a_p12_in_only: assert property (p12_pad.oe[7:1] == 7'h00)
    else $error("port 12 input-only pin driven");
  a_p13_reset_low: assert property (disable iff (1'b0) !rst_n |-> !port13_output_pin)
    else $error("port 13 not low in reset");
  a_flash_pd_reset: assert property (disable iff (1'b0)
                                     !rst_n |-> flash_mode_pin_pull_down)
    else $error("flash pin not pulled down in reset");
  a_flash_pu_self: assert property (self_prog_active && st_reg.rst_done
                                    |-> flash_mode_pin_pull_up && !flash_mode_pin_pull_down)
    else $error("flash pin not pulled up in self-programming");
  a_ext_rise_evt: assert property (ext_en[0] && st_reg.edge_sel[0] && !st_reg.ext_prev[0]
                                   && p12_in[0] |=> port12_external_irq_input
                                   && st_reg.irq_status[EXT_IRQ_LSB])
    else $error("rising edge lost");
  a_ext_no_fall: assert property (ext_en[0] && !st_reg.edge_sel[1] && st_reg.ext_prev[0]
                                  && !p12_in[0] |=> !port12_external_irq_input)
    else $error("falling edge taken while disabled");
  a_p14_od_drive: assert property (st_reg.p14_mode[P14_OD_LSB+2]
                                   |-> !(p14_pad.oe[2] && p14_pad.out[2]))
    else $error("port 14 open-drain pin drove high");
  a_alt_drive: assert property (st_reg.cfg[IDX_P14][CFG_CTL_LSB]
                                |-> p14_pad.oe[0] == p14_alt_oe[0])
    else $error("alternate enable not on pin");
  a_wr_resp: assert property (wr_fire |=> s_axi_bvalid)
    else $error("write response missing");

  c_key_event: cover property (key_evt != 8'h00);
  c_irq_raise: cover property ($rose(irq));
  c_wr_then_rd: cover property (s_axi_bvalid && s_axi_bready ##[1:4] s_axi_rvalid);

endmodule : ppfc_top
`default_nettype wire

// *** dv/ppfc_pin_model.sv ***
`default_nettype none
module ppfc_pin_model #(
  parameter int W = 8
) (
  input  wire ppfc_pkg::ppfc_pad_s pad, // Drive from the port
  input  wire logic [W-1:0]        ext, // Far-side level on a free pin
  output logic [W-1:0]             lvl  // Resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Open-drain bits only pull low; a released pin shows the far circuit
  always_comb begin
    for (int i = 0; i < W; i++) lvl[i] = pad.oe[i] ? pad.out[i] : ext[i];
  end
endmodule : ppfc_pin_model
`default_nettype wire

// *** dv/ppfc_tb_top.sv ***
`default_nettype none
module ppfc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ppfc_pkg::*;
  logic core_clk = 1'b0, rst_n, p9_in, self_prog_active, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, port12_external_irq_input;
  logic port13_output_pin, dac_output_0, dac_output_1, flash_mode_pin_pull_up;
  logic flash_mode_pin_pull_down;
  logic [7:0] s_axi_awaddr, s_axi_araddr, p6_in, p7_in, p6_alt_out, p6_alt_oe;
  logic [7:0] key_interrupt_inputs, ext = 8'h00;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d, v;
  logic [3:0] s_axi_wstrb, port7_external_irq_inputs;
  logic [1:0] s_axi_bresp, s_axi_rresp, p11_in, port14_ttl_select, rd_r;
  logic [4:0] p12_in;
  logic [5:0] p14_in, p14_alt_out, p14_alt_oe;
  ppfc_pad_s p6_pad, p7_pad, p9_pad, p11_pad, p12_pad, p14_pad;
  int fail_count = 0, total_checks = 0, pulses = 0, p0;
  ppfc_top dut_u (.*);
  ppfc_pin_model m6 (.pad(p6_pad), .ext(ext), .lvl(p6_in));
  ppfc_pin_model m7 (.pad(p7_pad), .ext(ext), .lvl(p7_in));
  ppfc_pin_model #(.W(5)) m12 (.pad(p12_pad), .ext(ext[4:0]), .lvl(p12_in));
  ppfc_pin_model #(.W(6)) m14 (.pad(p14_pad), .ext(ext[5:0]), .lvl(p14_in));
  initial forever #4 core_clk = ~core_clk;
  // Count one-cycle event pulses so a stuck-high pulse shows up
  always @(posedge core_clk) if (port12_external_irq_input) pulses <= pulses + 1;
  function automatic logic [7:0] p6_oe_exp(input logic [31:0] c);
    return ~c[7:0] & {4'hF, ~c[19:16]};
  endfunction : p6_oe_exp
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  // Valid and payload hold until their own ready edge; bready and rready stay high
  // all run, so back-to-back calls never drive them twice in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
  endtask : rd
  initial begin
    repeat (2000) @(posedge core_clk);
    fail_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_arvalid, p9_in, p11_in, self_prog_active} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    // Reset falls by NBA so the state register sees a real edge at time zero
    rst_n <= 1'b0;
    s_axi_wstrb = 4'hF;
    void'($urandom(34973));
    {p6_alt_out, p6_alt_oe, p14_alt_out, p14_alt_oe} = 28'($urandom);
    repeat (3) @(posedge core_clk);
    chk("p13_rst", 32'h0, port13_output_pin);
    chk("flash_pd", 32'h1, flash_mode_pin_pull_down);
    rst_n <= 1'b1;
    rd(ADDR_P6_CFG);
    chk("p6_cfg_rst", CFG_RST[IDX_P6], rd_d);
    rd(8'h40);
    chk("unmapped", {30'h0, RESP_SLVERR}, rd_d | {30'h0, rd_r});
    repeat (4) begin
      v = $urandom & 32'h00FF_FFFF;
      wr(ADDR_P6_CFG, v);
      chk("p6_oe", p6_oe_exp(v), p6_pad.oe);
      chk("p6_out", 8'(v[23:16] & ~v[7:0] & 8'hF0), p6_pad.out & p6_pad.oe);
      chk("p6_pu", 8'(v[15:8] & v[7:0] & 8'hF0), p6_pad.pull_up);
    end
    wr(ADDR_P14_CFG, 32'h3F00_003F);
    chk("p14_alt_oe", p14_alt_oe, p14_pad.oe[5:0]);
    wr(ADDR_P14_MODE, 32'h0000_1C0C);
    chk("p14_od_oe", 6'(p14_alt_oe & ~(p14_alt_out & 6'h1C)), p14_pad.oe[5:0]);
    chk("p14_ttl", 32'h3, port14_ttl_select);
    wr(ADDR_P9_CFG, 32'h0001_0100);
    chk("p9_pad", 32'h0001_0100, p9_pad);
    wr(ADDR_P11_CFG, 32'h0300_0003);
    chk("dac", 32'h3, {dac_output_1, dac_output_0});
    wr(ADDR_P12_CFG, 32'h0100_0001);
    wr(ADDR_IRQ_MASK, 32'h0000_0100);
    wr(ADDR_P7_CFG, 32'hFF00_00FF);
    for (int m = 1; m < 4; m++) begin
      wr(ADDR_EDGE_SEL, 32'(m));
      p0 = pulses;
      ext <= 8'h01;
      repeat (3) @(posedge core_clk);
      chk("irq_rise", m[0], irq);
      chk("key_lvl", 32'h1, key_interrupt_inputs);
      wr(ADDR_IRQ_STAT, 32'h0000_0100);
      ext <= 8'h00;
      repeat (3) @(posedge core_clk);
      chk("irq_fall", m[1], irq);
      chk("pulses", $countones(m), pulses - p0);
      wr(ADDR_IRQ_STAT, 32'h0000_0100);
    end
    chk("irq_clr", 32'h0, irq);
    wr(ADDR_P13_LATCH, 32'h1);
    chk("p13_set", 32'h1, port13_output_pin);
    chk("flash_pd_run", 32'h1, flash_mode_pin_pull_down);
    self_prog_active <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("flash_pu", 32'h1, flash_mode_pin_pull_up);
    rst_n <= 1'b0;
    @(posedge core_clk);
    chk("p13_rst2", 32'h0, port13_output_pin);
    end_sim();
  end
endmodule : ppfc_tb_top
`default_nettype wire
